// ===== src/trig_seq_pkg.sv
`default_nettype none
package trig_seq_pkg;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
		logic        code_fetch;
		logic        queue_flush_flag;
		logic        rw;
		logic        mio;
		logic        irq;
		logic [2:0]  queue_depth_field;
	} bus_word_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef enum logic [1:0] {
		SEQ_ONE   = 2'h0,
		SEQ_TWO   = 2'h1,
		SEQ_THREE = 2'h3,
		SEQ_FOUR  = 2'h2
	} seq_state_t;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] MATCH_BASE = 8'h00; // four blocks of 0x10
	localparam logic [7:0] MATCH_ADDR_PAT = 8'h0;
	localparam logic [7:0] MATCH_ADDR_CARE = 8'h4;
	localparam logic [7:0] MATCH_DATA = 8'h8; // pattern low, care high
	localparam logic [7:0] MATCH_FLAGS = 8'hC; // pattern [7:0], care [15:8]
	localparam logic [7:0] CTRL_OFS = 8'h40;
	localparam logic [7:0] STATUS_OFS = 8'h44;
	localparam logic [7:0] INT_STAT_OFS = 8'h48;
	localparam logic [7:0] INT_MASK_OFS = 8'h4C;
	localparam logic [7:0] COUNT_ONE_OFS = 8'h50;
	localparam logic [7:0] COUNT_TWO_OFS = 8'h54;
	// Control bits
	localparam int CTRL_SINGLE = 0;
	localparam int CTRL_STORE = 1;
	localparam int CTRL_DISPLAY = 2;
	// Event bits, shared by status and mask
	localparam int EV_MAIN = 0;
	localparam int EV_TIMING = 1;
	localparam int EV_SLOW = 2;
	localparam int EV_W = 3;
	localparam logic [EV_W-1:0] INT_MASK_RST = 3'h0;
	// Slow-clock detector: longest allowed gap between sample edges
	localparam int SLOW_GAP_NS = 10000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SLOW_GAP_CYC = SLOW_GAP_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
endpackage
`default_nettype wire

// ===== src/trig_seq.sv
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`default_nettype none
module trig_seq (
	input  wire logic                   clk_i,
	input  wire logic                   rst_b_i,
	input  wire trig_seq_pkg::wb_req_t  wb_req_i,
	output logic [31:0]                 wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic                   probe_clk_i,
	input  wire trig_seq_pkg::bus_word_t probe_bus_i,
	output trig_seq_pkg::bus_word_t     store_word_o,
	output logic                        store_strobe_o,
	output logic                        main_trig_o,
	output logic                        timing_trig_o,
	output logic                        irq_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		trig_seq_pkg::bus_word_t [3:0] pat;
		trig_seq_pkg::bus_word_t [3:0] care;
		logic [2:0]                     clk_sync;
		trig_seq_pkg::bus_word_t        bus_s1;
		trig_seq_pkg::bus_word_t        bus_s2;
		logic                           single;
		logic                           storing;
		trig_seq_pkg::seq_state_t       state;
		logic [trig_seq_pkg::CNT_W-1:0] cnt_one;
		logic [trig_seq_pkg::CNT_W-1:0] cnt_two;
		logic [10:0]                    gap;
		logic                           slow;
		logic [trig_seq_pkg::EV_W-1:0]  int_stat;
		logic [trig_seq_pkg::EV_W-1:0]  int_mask;
		trig_seq_pkg::bus_word_t        store_word;
		logic                           store_strobe;
		logic                           main_trig;
		logic                           timing_trig;
		logic                           ack;
		logic [31:0]                    rdat;
	} state_t;

	localparam logic [10:0] SLOW_LIMIT = 11'(trig_seq_pkg::SLOW_GAP_CYC);

	state_t s_q;
	state_t s_d;
	logic   sample_en;
	logic [3:0] hit;

	// Merge a write into an old word under the byte selects
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction

	// ----------------------------------------
	// Word matchers
	// ----------------------------------------
	// Falling probe edge seen past the synchroniser; delay by two is the sync itself
	assign sample_en = s_q.clk_sync[2] & ~s_q.clk_sync[1];

	// Each matcher compares only the fields whose care bits are set
	for (genvar i = 0; i < 4; i++) begin : g_match
		assign hit[i] = ((s_q.bus_s2 ^ s_q.pat[i]) & s_q.care[i]) == '0;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic                          wr;
		logic                          rd_cycle;
		logic [1:0]                    idx;
		logic [3:0]                    ofs;
		logic [31:0]                   old;
		logic [31:0]                   nw;
		logic [trig_seq_pkg::EV_W-1:0] ev;
		s_d = s_q;
		rd_cycle = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
		wr = rd_cycle & wb_req_i.we;
		idx = wb_req_i.adr[5:4];
		ofs = wb_req_i.adr[3:0];
		old = '0;
		nw = '0;
		ev = '0;
		s_d.store_strobe = 1'b0;
		s_d.main_trig = 1'b0;
		s_d.timing_trig = 1'b0;
		s_d.ack = rd_cycle;

		// Two-stage synchronisers for probe clock and bus word
		s_d.clk_sync = {s_q.clk_sync[1:0], probe_clk_i};
		s_d.bus_s1 = probe_bus_i;
		s_d.bus_s2 = s_q.bus_s1;

		// Slow-clock detector: gap since last sampling edge
		if (sample_en) begin
			s_d.gap = '0;
			s_d.slow = 1'b0;
		end else if (s_q.gap >= SLOW_LIMIT) begin
			s_d.slow = 1'b1;
		end else begin
			s_d.gap = s_q.gap + 11'h001;
		end
		ev[trig_seq_pkg::EV_SLOW] = s_d.slow & ~s_q.slow;

		// Trigger program, active only in store mode
		if (sample_en && s_q.storing) begin
			if (s_q.single) begin
				if (hit[0]) begin
					s_d.main_trig = 1'b1;
					s_d.timing_trig = 1'b1;
					s_d.storing = 1'b0;
				end
			end else begin
				unique case (s_q.state)
					trig_seq_pkg::SEQ_ONE: begin
						// Holds with counters frozen until the first hit
						if (hit[0]) begin
							s_d.state = trig_seq_pkg::SEQ_TWO;
							s_d.cnt_one = '0;
							s_d.cnt_two = '0;
						end
					end
					trig_seq_pkg::SEQ_TWO: begin
						if (hit[1]) s_d.state = trig_seq_pkg::SEQ_THREE;
						else s_d.cnt_one = s_q.cnt_one + 16'h0001;
					end
					trig_seq_pkg::SEQ_THREE: begin
						if (hit[2]) s_d.state = trig_seq_pkg::SEQ_FOUR;
						else s_d.cnt_two = s_q.cnt_two + 16'h0001;
					end
					trig_seq_pkg::SEQ_FOUR: begin
						if (hit[3]) begin
							s_d.main_trig = 1'b1;
							s_d.timing_trig = 1'b1;
							s_d.storing = 1'b0; // back to display mode
						end else begin
							s_d.store_strobe = 1'b1;
							s_d.store_word = s_q.bus_s2;
						end
					end
				endcase
			end
		end
		ev[trig_seq_pkg::EV_MAIN] = s_d.main_trig;
		ev[trig_seq_pkg::EV_TIMING] = s_d.timing_trig;

		// Register writes; commands override the sequencer
		if (wr && wb_req_i.adr < trig_seq_pkg::CTRL_OFS) begin
			unique case (ofs)
				trig_seq_pkg::MATCH_ADDR_PAT[3:0]: old = 32'(s_q.pat[idx].addr);
				trig_seq_pkg::MATCH_ADDR_CARE[3:0]: old = 32'(s_q.care[idx].addr);
				trig_seq_pkg::MATCH_DATA[3:0]: old = {s_q.care[idx].data, s_q.pat[idx].data};
				trig_seq_pkg::MATCH_FLAGS[3:0]: old = {16'h0000, s_q.care[idx][7:0],
						s_q.pat[idx][7:0]};
				default: old = '0;
			endcase
			nw = merge(old, wb_req_i.dat, wb_req_i.sel);
			unique case (ofs)
				trig_seq_pkg::MATCH_ADDR_PAT[3:0]: s_d.pat[idx].addr = nw[19:0];
				trig_seq_pkg::MATCH_ADDR_CARE[3:0]: s_d.care[idx].addr = nw[19:0];
				trig_seq_pkg::MATCH_DATA[3:0]: begin
					s_d.pat[idx].data = nw[15:0];
					s_d.care[idx].data = nw[31:16];
				end
				trig_seq_pkg::MATCH_FLAGS[3:0]: begin
					s_d.pat[idx][7:0] = nw[7:0];
					s_d.care[idx][7:0] = nw[15:8];
				end
				default: ;
			endcase
		end else if (wr && wb_req_i.sel[0]) begin
			if (wb_req_i.adr == trig_seq_pkg::CTRL_OFS) begin
				s_d.single = wb_req_i.dat[trig_seq_pkg::CTRL_SINGLE];
				// Store restarts the program from state one
				if (wb_req_i.dat[trig_seq_pkg::CTRL_STORE]) begin
					s_d.storing = 1'b1;
					s_d.state = trig_seq_pkg::SEQ_ONE;
				end
				if (wb_req_i.dat[trig_seq_pkg::CTRL_DISPLAY]) s_d.storing = 1'b0;
			end
			if (wb_req_i.adr == trig_seq_pkg::INT_MASK_OFS) begin
				s_d.int_mask = wb_req_i.dat[trig_seq_pkg::EV_W-1:0];
			end
		end

		// Sticky events, write one to clear; a new event wins over the clear
		s_d.int_stat = s_q.int_stat;
		if (wr && wb_req_i.sel[0] && wb_req_i.adr == trig_seq_pkg::INT_STAT_OFS) begin
			s_d.int_stat = s_q.int_stat & ~wb_req_i.dat[trig_seq_pkg::EV_W-1:0];
		end
		s_d.int_stat = s_d.int_stat | ev;

		// Read data, captured with the acknowledge; unmapped reads return zero
		s_d.rdat = '0;
		if (rd_cycle && !wb_req_i.we) begin
			if (wb_req_i.adr < trig_seq_pkg::CTRL_OFS) begin
				unique case (ofs)
					trig_seq_pkg::MATCH_ADDR_PAT[3:0]: s_d.rdat = 32'(s_q.pat[idx].addr);
					trig_seq_pkg::MATCH_ADDR_CARE[3:0]: s_d.rdat = 32'(s_q.care[idx].addr);
					trig_seq_pkg::MATCH_DATA[3:0]:
						s_d.rdat = {s_q.care[idx].data, s_q.pat[idx].data};
					trig_seq_pkg::MATCH_FLAGS[3:0]:
						s_d.rdat = {16'h0000, s_q.care[idx][7:0], s_q.pat[idx][7:0]};
					default: s_d.rdat = '0;
				endcase
			end else begin
				unique case (wb_req_i.adr)
					trig_seq_pkg::CTRL_OFS: s_d.rdat = {31'h00000000, s_q.single};
					trig_seq_pkg::STATUS_OFS:
						s_d.rdat = {28'h0000000, s_q.slow, s_q.state, s_q.storing};
					trig_seq_pkg::INT_STAT_OFS: s_d.rdat = 32'(s_q.int_stat);
					trig_seq_pkg::INT_MASK_OFS: s_d.rdat = 32'(s_q.int_mask);
					trig_seq_pkg::COUNT_ONE_OFS: s_d.rdat = 32'(s_q.cnt_one);
					trig_seq_pkg::COUNT_TWO_OFS: s_d.rdat = 32'(s_q.cnt_two);
					default: s_d.rdat = '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Patterns reset to all don't-care so every word hits; nothing fires until a store command
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.int_mask <= trig_seq_pkg::INT_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
	assign store_word_o = s_q.store_word;
	assign store_strobe_o = s_q.store_strobe;
	assign main_trig_o = s_q.main_trig;
	assign timing_trig_o = s_q.timing_trig;
	assign irq_o = |(s_q.int_stat & s_q.int_mask);
endmodule
`default_nettype wire

// ===== test/stim_fixture.sv
`default_nettype none
module stim_fixture (
	output logic                    probe_clk_o,
	output trig_seq_pkg::bus_word_t probe_bus_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Bus cycle generator
	// ----------------------------------------
	// Clock idles high between cycles, so no stray falling edge
	initial begin
		probe_clk_o = 1'b1;
		probe_bus_o = '0;
	end
	// Word set up, falling edge samples it, then bus shows the inverse
	// so a late capture can never pass on a stale word
	task automatic send(input trig_seq_pkg::bus_word_t w);
		#2 probe_bus_o = w;
		#50 probe_clk_o = 1'b0;
		#50 probe_clk_o = 1'b1;
		probe_bus_o = ~w;
		#50;
	endtask
endmodule
`default_nettype wire

// ===== test/trig_seq_chk.sv
`default_nettype none
module trig_seq_chk (
	input wire logic                    clk_i,
	input wire logic                    rst_b_i,
	input wire trig_seq_pkg::wb_req_t   wb_req_i,
	input wire logic [31:0]             wb_dat_o,
	input wire logic                    wb_ack_o,
	input wire logic                    probe_clk_i,
	input wire trig_seq_pkg::bus_word_t probe_bus_i,
	input wire trig_seq_pkg::bus_word_t store_word_o,
	input wire logic                    store_strobe_o,
	input wire logic                    main_trig_o,
	input wire logic                    timing_trig_o,
	input wire logic                    irq_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Request taken; sample edge seen a few cycles back through the sync
	sequence s_taken;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	endsequence
	sequence s_sampled;
		!$past(probe_clk_i, 2) && $past(probe_clk_i, 6);
	endsequence
	a_ack_next: assert property (s_taken |=> wb_ack_o) else $error("no ack after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_unmapped_zero: assert property (s_taken ##0 (!wb_req_i.we && wb_req_i.adr == 8'hFC)
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_trig_pair: assert property (main_trig_o |-> timing_trig_o) else $error("lone main");
	a_hit_unstored: assert property (store_strobe_o |-> !main_trig_o) else $error("hit stored");
	a_trig_once: assert property (main_trig_o |=> !main_trig_o) else $error("double trig");
	a_store_pulse: assert property (store_strobe_o |=> !store_strobe_o) else $error("long store");
	a_store_edge: assert property (store_strobe_o |-> s_sampled) else $error("store no edge");
	a_trig_edge: assert property (main_trig_o |-> s_sampled) else $error("trig no edge");
	a_word_hold: assert property (!store_strobe_o |-> $stable(store_word_o))
		else $error("stored word moved");
endmodule
bind trig_seq trig_seq_chk i_chk (.clk_i, .rst_b_i, .wb_req_i, .wb_dat_o, .wb_ack_o, .probe_clk_i,
	.probe_bus_i, .store_word_o, .store_strobe_o, .main_trig_o, .timing_trig_o, .irq_o);
`default_nettype wire

// ===== test/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	logic                    clk_i = 1'b0;
	logic                    rst_b_i = 1'b0;
	trig_seq_pkg::wb_req_t   wb_req_i = '0;
	logic [31:0]             wb_dat_o;
	logic                    wb_ack_o;
	logic                    probe_clk_i;
	trig_seq_pkg::bus_word_t probe_bus_i;
	trig_seq_pkg::bus_word_t store_word_o;
	trig_seq_pkg::bus_word_t last_store;
	logic                    store_strobe_o;
	logic                    main_trig_o;
	logic                    timing_trig_o;
	logic                    irq_o;
	logic [31:0]             q;
	logic [19:0]             pat [4] = '{20'h66908, 20'h44FF4, 20'hF0000, 20'h0FFFF};
	// Data care high, pattern low; flags care [15:8], pattern [7:0]
	logic [31:0]             dpat [4] = '{32'hFFFF96F6, 32'h00000000,
		32'hFFFFFFFE, 32'hFFFF0000};
	logic [31:0]             fpat [4] = '{32'h00008784, 32'h00008783,
		32'h00008700, 32'h00000F0A};
	int                      failures = 0;
	int                      n_checks = 0;
	int                      n_main = 0;
	int                      n_timing = 0;
	int                      n_store = 0;
	always #5 clk_i = ~clk_i;
	trig_seq i_dut (.clk_i, .rst_b_i, .wb_req_i, .wb_dat_o, .wb_ack_o, .probe_clk_i, .probe_bus_i,
		.store_word_o, .store_strobe_o, .main_trig_o, .timing_trig_o, .irq_o);
	stim_fixture i_fix (.probe_clk_o(probe_clk_i), .probe_bus_o(probe_bus_i));
	// Strobes stand one cycle, so tally them at every edge
	always @(posedge clk_i) begin
		if (main_trig_o === 1'b1) n_main <= n_main + 1;
		if (timing_trig_o === 1'b1) n_timing <= n_timing + 1;
		if (store_strobe_o === 1'b1) begin
			n_store <= n_store + 1;
			last_store <= store_word_o;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [43:0] g, input logic [43:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Classic cycle; holds until ack, then one idle cycle
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		q = wb_dat_o;
		wb_req_i <= '0;
		@(posedge clk_i);
		if (k >= 50) chk(44'h0, 44'h1);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Flags byte: code fetch, flush, rw, mio, irq, then three depth bits
	function automatic trig_seq_pkg::bus_word_t bw(input logic [19:0] a, input logic [15:0] d,
			input logic [7:0] f);
		trig_seq_pkg::bus_word_t w;
		w = '0;
		w.addr = a;
		w.data = d;
		w[7:0] = f;
		bw = w;
	endfunction
	// Realign to a clock edge after the asynchronous bus cycle
	task automatic tx(input logic [19:0] a, input logic [15:0] d, input logic [7:0] f);
		i_fix.send(bw(a, d, f));
		@(posedge clk_i);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		// Load all four matchers: address fully cared, data and flags per matcher
		for (int n = 0; n < 4; n++) begin
			xfer(1'b1, 8'(n * 16), {12'h0, pat[n]});
			xfer(1'b1, 8'(n * 16 + 4), 32'h000F_FFFF);
			xfer(1'b1, 8'(n * 16 + 8), dpat[n]);
			xfer(1'b1, 8'(n * 16 + 12), fpat[n]);
		end
		xfer(1'b1, 8'h4C, 32'h1);
		// Front end stays at its defaults; display, then check the status reads zero
		xfer(1'b1, 8'h40, 32'h4);
		rc(8'h44, 32'h0);
		xfer(1'b1, 8'h40, 32'h2);
		tx(20'h66908, 16'h96F7, 8'h84);
		tx(20'h12345, 16'h1234, 8'h84);
		rc(8'h44, 32'h1);
		tx(20'h66908, 16'h96F6, 8'h84);
		rc(8'h44, 32'h3);
		// Wrong queue depth must not fire matcher two, so it counts
		tx(20'h12345, 16'h1234, 8'h84);
		tx(20'h44FF4, 16'h0000, 8'h84);
		tx(20'h44FF4, 16'h0000, 8'h83);
		rc(8'h44, 32'h7);
		tx(20'hF0000, 16'hFFFF, 8'h00);
		tx(20'hF0000, 16'hFFFE, 8'h00);
		rc(8'h44, 32'h5);
		tx(20'h0ABCD, 16'h5A5A, 8'h84);
		tx(20'h0FFFF, 16'h0000, 8'h0A);
		chk(n_store, 1);
		chk(last_store, bw(20'h0ABCD, 16'h5A5A, 8'h84));
		chk(n_main, 1);
		xfer(1'b0, 8'h44, 32'h0);
		chk(q[0], 1'b0);
		rc(8'h50, 32'h2);
		rc(8'h54, 32'h1);
		chk(irq_o, 1'b1);
		xfer(1'b1, 8'h4C, 32'h0);
		chk(irq_o, 1'b0);
		xfer(1'b1, 8'h4C, 32'h1);
		xfer(1'b1, 8'h48, 32'h1);
		chk(irq_o, 1'b0);
		// Second run: counts survive until the first matcher hits
		xfer(1'b1, 8'h40, 32'h2);
		tx(20'h12345, 16'h1234, 8'h84);
		rc(8'h50, 32'h2);
		tx(20'h66908, 16'h96F6, 8'h84);
		rc(8'h50, 32'h0);
		rc(8'h54, 32'h0);
		xfer(1'b1, 8'h40, 32'h4);
		xfer(1'b0, 8'h44, 32'h0);
		chk(q[0], 1'b0);
		xfer(1'b1, 8'h40, 32'h3);
		tx(20'h66908, 16'h96F6, 8'h84);
		chk(n_main, 2);
		chk(n_timing, 2);
		rc(8'hFC, 32'h0);
		// Probe clock idle past the gap limit: slow flag and its event
		repeat (1010) @(posedge clk_i);
		rc(8'h44, 32'h8);
		rc(8'h48, 32'h7);
		tx(20'h12345, 16'h1234, 8'h84);
		rc(8'h44, 32'h0);
		summarize();
	end
	// Whole run takes under twenty microseconds
	initial begin
		#200000;
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
